// [hw/xop_unit.sv]
// extended pointer, frame-return, call-via-w and indexed move unit
// Function
// - add the 6-bit literal to the indirect pointer picked by a 0..2 selector, one cycle, flags untouched.
// - the frame-return form adds the literal to the frame pointer then loads the pc from the return top.
// - the frame-return form takes two instruction cycles, the second idle.
// - a selector of 11 decodes as the frame-return form acting on the frame pointer.
// - call-via-w first pushes pc plus 2 onto the return stack.
// - call-via-w then replaces the pc low byte with the working register.
// - call-via-w copies the high latch and upper latch into pc high and upper bytes.
// - call-via-w is one word, two cycles, the second idle while the target fetches.
// - call-via-w leaves working register, status and bank selector alone.
// - indexed move reads frame pointer plus 7-bit offset and writes an absolute address, flags untouched.
// - the indexed move destination is the 12-bit literal of the second word.
// - a source address on an indirect access register reads as 00h.
// - extended ops are decoded only while the extended set enable is high.
`timescale 1ns/1ps
`default_nettype none
module xop_unit
  import xop_pkg::*;
#(
  parameter int NPTR = 3
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic extended_set_enable,
  input wire xop_pkg::xop_insn_t insn,
  input wire logic [7:0] working_register,
  input wire logic [7:0] counter_high_latch,
  input wire logic [7:0] counter_upper_latch,
  input wire logic [xop_pkg::PC_W-1:0] return_stack_top,
  input wire logic [7:0] mem_rd_data,
  output logic insn_ready,
  output logic claimed,
  output logic [xop_pkg::ADDR_W-1:0] mem_rd_addr,
  output xop_pkg::xop_mem_wr_t mem_wr,
  output logic push_r,
  output logic [xop_pkg::PC_W-1:0] push_data_r,
  output logic pop_r,
  output logic pc_load_r,
  output logic [xop_pkg::PC_W-1:0] pc_new_r,
  output logic [xop_pkg::PTR_W-1:0] indirect_pointer0,
  output logic [xop_pkg::PTR_W-1:0] indirect_pointer1,
  output logic [xop_pkg::PTR_W-1:0] frame_pointer
);
  import xop_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [PTR_W-1:0] ptr_add(
    input logic [PTR_W-1:0] p,
    input logic [PTR_W-1:0] k
  );
    ptr_add = p + k;
  endfunction

  function automatic logic is_indf(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] rel;
    rel = a & INDF_MASK;
    is_indf = (rel == (INDF_BASE & INDF_MASK))
      || (rel == ((INDF_BASE - INDF_STRIDE) & INDF_MASK))
      || (rel == ((INDF_BASE - INDF_STRIDE - INDF_STRIDE) & INDF_MASK));
    is_indf = is_indf && (a[2:0] >= INDF_LOW) && (a[2:0] <= INDF_HIGH);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  xop_state_t state_r, state_nxt;
  logic [PTR_W-1:0] ptr_r [NPTR];
  logic [7:0] src_data_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic idle = (state_r == XOP_IDLE);
  wire logic go = insn.valid && idle && extended_set_enable;
  wire logic [1:0] sel = insn.word[7:6];
  wire logic add_op = go && (insn.word[15:8] == OPC_ADD_PTR);
  wire logic dec_add = add_op && (sel != SEL_FRAME);
  wire logic dec_ret = add_op && (sel == SEL_FRAME);
  wire logic dec_call = go && (insn.word == OPC_CALL_W);
  wire logic dec_move = go && (insn.word[15:7] == OPC_MOVE_IDX);
  wire logic second_ok = insn.valid && (insn.word[15:12] == OPC_SECOND);
  wire logic [PTR_W-1:0] lit = PTR_W'(insn.word[LIT_W-1:0]);
  wire logic [PTR_W-1:0] ofs = PTR_W'(insn.word[OFS_W-1:0]);
  wire logic [1:0] tgt = dec_ret ? FRAME_IDX : sel;
  wire logic [ADDR_W-1:0] src_addr =
    ADDR_W'(ptr_add(ptr_r[FRAME_IDX], ofs));
  wire logic [7:0] src_val =
    is_indf(src_addr) ? READ_ZERO : mem_rd_data;

  assign mem_rd_addr = src_addr;
  assign insn_ready = idle || (state_r == XOP_MOVE2) || (state_r == XOP_NOP);
  assign claimed = dec_add || dec_ret || dec_call || dec_move || !idle;
  assign indirect_pointer0 = ptr_r[0];
  assign indirect_pointer1 = ptr_r[1];
  assign frame_pointer = ptr_r[FRAME_IDX];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      XOP_IDLE: begin
        if (dec_ret || dec_call) begin
          state_nxt = XOP_NOP;
        end else if (dec_move) begin
          state_nxt = XOP_MOVE2;
        end
      end
      XOP_NOP: state_nxt = XOP_IDLE;
      XOP_MOVE2: begin
        if (second_ok) begin
          state_nxt = XOP_IDLE;
        end
      end
      default: state_nxt = XOP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= XOP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // pointer file
  // ----------------------------------------
  // flags are not touched anywhere here, so status stays as it was
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NPTR; i++) begin
        ptr_r[i] <= '0;
      end
    end else if (dec_add || dec_ret) begin
      ptr_r[tgt] <= ptr_add(ptr_r[tgt], lit);
    end
  end

  // ----------------------------------------
  // program flow
  // ----------------------------------------
  // working register and bank selector are inputs only: never altered
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_r <= 1'b0;
      push_data_r <= '0;
      pop_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_new_r <= '0;
    end else begin
      push_r <= dec_call;
      pop_r <= dec_ret;
      pc_load_r <= dec_call || dec_ret;
      if (dec_call) begin
        push_data_r <= insn.pc + PC_STEP;
        pc_new_r <= PC_W'({counter_upper_latch, counter_high_latch,
          working_register});
      end else if (dec_ret) begin
        pc_new_r <= return_stack_top;
      end
    end
  end

  // ----------------------------------------
  // indexed move
  // ----------------------------------------
  // pc low and return-top destinations are not trapped; software avoids them
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_data_r <= '0;
      mem_wr <= '0;
    end else begin
      mem_wr.we <= 1'b0;
      if (dec_move) begin
        src_data_r <= src_val;
      end
      if (state_r == XOP_MOVE2 && second_ok) begin
        mem_wr.we <= 1'b1;
        mem_wr.addr <= insn.word[ADDR_W-1:0];
        mem_wr.data <= src_data_r;
      end
    end
  end
endmodule // xop_unit
`default_nettype wire

// [pkg/xop_pkg.sv]
// package: encodings, field layouts and state for the extended op unit
package xop_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int PTR_W = 12;
  localparam int PC_W = 21;
  localparam int INSN_W = 16;
  localparam int ADDR_W = 12;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [7:0] OPC_ADD_PTR = 8'h00E8;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam logic [8:0] OPC_MOVE_IDX = 9'h01D6;
  localparam logic [3:0] OPC_SECOND = 4'hF;
  localparam logic [1:0] SEL_FRAME = 2'h3;
  localparam logic [1:0] FRAME_IDX = 2'h2;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] INDF_BASE = 12'h0FEF;
  localparam logic [ADDR_W-1:0] INDF_STRIDE = 12'h0008;
  localparam logic [ADDR_W-1:0] INDF_MASK = 12'h0FF8;
  localparam logic [2:0] INDF_LOW = 3'h3;
  localparam logic [2:0] INDF_HIGH = 3'h7;
  localparam int OFS_W = 7;
  localparam int LIT_W = 6;
  // ----------------------------------------
  // sequencing state
  // ----------------------------------------
  typedef enum logic [1:0] {
    XOP_IDLE = 2'b00,
    XOP_NOP = 2'b01,
    XOP_MOVE2 = 2'b11
  } xop_state_t;
  typedef struct packed {
    logic valid;
    logic [INSN_W-1:0] word;
    logic [PC_W-1:0] pc;
  } xop_insn_t;
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } xop_mem_wr_t;
endpackage

// [test/xop_unit_asserts.sv]
// port-level assertions for the extended op unit
`timescale 1ns/1ps
`default_nettype none
module xop_unit_asserts
  import xop_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic extended_set_enable,
  input wire xop_pkg::xop_insn_t insn,
  input wire logic [7:0] working_register,
  input wire logic [7:0] counter_high_latch,
  input wire logic [7:0] counter_upper_latch,
  input wire logic [xop_pkg::PC_W-1:0] return_stack_top,
  input wire logic [7:0] mem_rd_data,
  input wire logic [xop_pkg::ADDR_W-1:0] mem_rd_addr,
  input wire xop_pkg::xop_mem_wr_t mem_wr,
  input wire logic push_r,
  input wire logic [xop_pkg::PC_W-1:0] push_data_r,
  input wire logic pop_r,
  input wire logic pc_load_r,
  input wire logic [xop_pkg::PC_W-1:0] pc_new_r,
  input wire logic [xop_pkg::PTR_W-1:0] indirect_pointer0,
  input wire logic [xop_pkg::PTR_W-1:0] frame_pointer
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // pc_load_r marks the idle cycle, where words are ignored
  wire logic go = insn.valid && extended_set_enable && !pc_load_r;
  // only the three indirect blocks below the core's own top registers
  wire logic ind = mem_rd_addr >= 12'h0FDB && mem_rd_addr <= 12'h0FEF &&
    mem_rd_addr[2:0] >= INDF_LOW;
  call_push_a: assert property (
    go && insn.word == OPC_CALL_W |=> push_r &&
    push_data_r == $past(insn.pc) + PC_STEP) else $error("call push");
  call_target_a: assert property (
    go && insn.word == OPC_CALL_W |=> pc_load_r && !pop_r &&
    pc_new_r == PC_W'({$past(counter_upper_latch),
    $past(counter_high_latch), $past(working_register)}))
    else $error("call target");
  frame_ret_a: assert property (
    go && insn.word[15:6] == {OPC_ADD_PTR, SEL_FRAME} |=> pop_r &&
    pc_load_r && pc_new_r == $past(return_stack_top) && frame_pointer ==
    $past(frame_pointer) + $past(insn.word[5:0])) else $error("return");
  idle_second_a: assert property (
    pc_load_r |=> !pc_load_r && !push_r && $stable(frame_pointer) &&
    $stable(indirect_pointer0)) else $error("second cycle busy");
  add_ptr_a: assert property (
    go && insn.word[15:6] == {OPC_ADD_PTR, 2'h0} |=> !pc_load_r &&
    indirect_pointer0 == $past(indirect_pointer0) + $past(insn.word[5:0])
    && $stable(frame_pointer)) else $error("pointer add");
  off_refused_a: assert property (
    !extended_set_enable |=> !push_r && !pop_r && !pc_load_r)
    else $error("decoded while off");
  move_dest_a: assert property (
    mem_wr.we |-> mem_wr.addr == $past(insn.word[11:0]) &&
    $past(insn.word[15:7], 2) == OPC_MOVE_IDX) else $error("move dest");
  move_src_a: assert property (
    mem_wr.we |-> mem_wr.data == ($past(ind, 2) ? READ_ZERO :
    $past(mem_rd_data, 2))) else $error("move data");
endmodule // xop_unit_asserts
bind xop_unit xop_unit_asserts u_xop_unit_asserts (.*);
`default_nettype wire

// [test/tb_xop_unit.sv]
// self-checking bench for the extended op unit
`timescale 1ns/1ps
`default_nettype none
module tb_xop_unit;
  import xop_pkg::*;
  logic sys_clk, sys_rst, extended_set_enable, insn_ready, claimed;
  xop_insn_t insn;
  logic [7:0] working_register, counter_high_latch, counter_upper_latch;
  logic [7:0] mem_rd_data, d;
  logic [PC_W-1:0] return_stack_top, push_data_r, pc_new_r;
  logic [ADDR_W-1:0] mem_rd_addr, a;
  xop_mem_wr_t mem_wr;
  logic push_r, pop_r, pc_load_r;
  logic [PTR_W-1:0] indirect_pointer0, indirect_pointer1, frame_pointer;
  logic [PTR_W-1:0] mp [3];
  int err_total, samples_checked, seed, i, k, s;
  xop_unit u_xop_unit (.*);
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic put(input logic [15:0] w);
    insn = '{1'b1, w, 21'($random(seed))};
    @(posedge sys_clk);
    #1;
  endtask
  task automatic ptrs();
    chk(indirect_pointer0, mp[0]);
    chk(indirect_pointer1, mp[1]);
    chk(frame_pointer, mp[2]);
  endtask
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h4b01_1bc8;
    {err_total, samples_checked, working_register, mem_rd_data} = '0;
    {counter_high_latch, counter_upper_latch, return_stack_top} = '0;
    {sys_rst, extended_set_enable, insn} = {2'b11, 38'h0};
    mp = '{default: '0};
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 0;
    ptrs();
    // long add run, 300 random adds spread over the three pointers
    for (i = 0; i < 300; i++) begin
      s = {$random(seed)} % 3;
      k = {$random(seed)} % 64;
      put({OPC_ADD_PTR, s[1:0], k[5:0]});
      mp[s] += k;
      ptrs();
    end
    for (i = 0; i < 8; i++) begin
      k = {$random(seed)} % 64;
      {working_register, counter_high_latch, counter_upper_latch} = 24'($random(seed));
      return_stack_top = 21'($random(seed));
      put(i[0] ? OPC_CALL_W : {OPC_ADD_PTR, SEL_FRAME, k[5:0]});
      chk({insn_ready, claimed}, 2'b11);
      if (i[0]) begin
        chk(push_data_r, 21'(insn.pc + PC_STEP));
        chk(pc_new_r, {counter_upper_latch[4:0], counter_high_latch, working_register});
      end else begin
        mp[2] += k;
        chk(pc_new_r, return_stack_top);
      end
      chk({push_r, pop_r, pc_load_r}, {i[0], !i[0], 1'b1});
      put({OPC_ADD_PTR, 2'h1, 6'h3f});
      chk(pc_load_r, 0);
      ptrs();
    end
    extended_set_enable = 0;
    put(OPC_CALL_W);
    chk(pc_load_r, 0);
    chk(claimed, 0);
    put({OPC_ADD_PTR, 2'h0, 6'h01});
    ptrs();
    extended_set_enable = 1;
    // bring the frame pointer near the indirect register block
    for (i = 0; i < 70 && mp[2] < 12'hF80; i++) begin
      put({OPC_ADD_PTR, FRAME_IDX, 6'h3f});
      mp[2] += 63;
    end
    chk(frame_pointer >= 12'hF80, 1);
    for (i = 0; i < 8; i++) begin
      k = 'hFEF - mp[2] - i * 3;
      a = mp[2] + k;
      d = 8'($random(seed));
      mem_rd_data = d;
      put({OPC_MOVE_IDX, k[6:0]});
      s = {$random(seed)} % 'hF00;
      put({OPC_SECOND, s[11:0]});
      chk({mem_wr.we, mem_wr.addr}, {1'b1, s[11:0]});
      chk(mem_wr.data, (a >= 12'hFDB && a[2:0] >= 3) ? 8'h00 : d);
    end
    complete_run();
  end
endmodule // tb_xop_unit
`default_nettype wire
